//--- common/scf_consts.vh
// constants for the command framing engine
`ifndef SCF_CONSTS_VH
`define SCF_CONSTS_VH

`define SCF_CMD_START    8'h66
`define SCF_CMD_WRMEM    8'h96
`define SCF_CMD_RDMEM    8'h44
`define SCF_CMD_AUTH     8'ha5
`define SCF_CMD_STATUS   8'haa
`define SCF_CMD_PROT     8'hc3
`define SCF_CMD_DECR     8'hc9
`define SCF_CMD_DISABLE  8'h33
`define SCF_CMD_RNG      8'hd2
`define SCF_CMD_KEYGEN   8'hcb

`define SCF_RELEASE_DEF  8'haa
`define SCF_MAX_LEN_DEF  8'h40

`define SCF_CRC_POLY     16'ha001
`define SCF_CRC_INIT     16'h0000
`define SCF_CRC_ONES     16'hffff

`define SCF_SEL_WR       0
`define SCF_SEL_RD       1
`define SCF_SEL_AUTH     2
`define SCF_SEL_OTHER    3

`endif

//--- hw/scf_crc16.v
// byte-wide crc-16, lsb first, reflected polynomial
`timescale 1ns/1ps
`include "scf_consts.vh"

module scf_crc16 (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        init,
  input  wire        en,
  input  wire [7:0]  din,
  output wire [15:0] crc
);

  reg [15:0] crc_r;

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        if (t[0])
          t = (t >> 1) ^ `SCF_CRC_POLY;
        else
          t = t >> 1;
      end
      crc_byte = t;
    end
  endfunction

  // ------------------------------------------------------------
  // register
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst || init) begin
      crc_r <= `SCF_CRC_INIT;
    end else if (en) begin
      crc_r <= crc_byte(crc_r, din);
    end
  end

  assign crc = crc_r;

endmodule

//--- hw/scf_framer.v
// device side command framing engine for a secure authenticator
//
// How it works
// - function commands accepted only after bus reset and rom select
// - command crc-16 follows code and parameters, checked before release
// - after delay master sends dummy; device returns length, then result if length is nonzero
// - result data bytes follow only as the length byte indicates
// - response ends with crc-16 over all bytes sent after dummy
// - decoder recognises write, read, authenticate and other codes
// - length counts code plus parameters; response uses same format
`timescale 1ns/1ps
`include "scf_consts.vh"

module scf_framer #(
  parameter [7:0] RELEASE_CODE = `SCF_RELEASE_DEF,
  parameter [7:0] MAX_LEN      = `SCF_MAX_LEN_DEF
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       bus_reset,
  input  wire       rom_sel_ok,
  input  wire       rx_valid,
  input  wire [7:0] rx_data,
  output wire       tx_valid,
  output reg  [7:0] tx_data,
  input  wire       tx_take,
  output reg        cmd_go,
  output reg  [7:0] cmd_code,
  output reg  [3:0] cmd_sel,
  output reg        param_valid,
  output reg  [7:0] param_data,
  output reg  [7:0] param_idx,
  input  wire       exec_done,
  input  wire [7:0] res_len,
  input  wire [7:0] res_byte,
  input  wire       res_data_valid,
  input  wire [7:0] res_data,
  output wire       res_data_take,
  output wire       high_current_pull_phase,
  output reg        frame_err
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [15:0] S_WRST  = 16'h0001;
  localparam [15:0] S_WROM  = 16'h0002;
  localparam [15:0] S_START = 16'h0004;
  localparam [15:0] S_LEN   = 16'h0008;
  localparam [15:0] S_CODE  = 16'h0010;
  localparam [15:0] S_PARM  = 16'h0020;
  localparam [15:0] S_CRCL  = 16'h0040;
  localparam [15:0] S_CRCH  = 16'h0080;
  localparam [15:0] S_REL   = 16'h0100;
  localparam [15:0] S_EXEC  = 16'h0200;
  localparam [15:0] S_DUMMY = 16'h0400;
  localparam [15:0] S_RLEN  = 16'h0800;
  localparam [15:0] S_RRES  = 16'h1000;
  localparam [15:0] S_RDATA = 16'h2000;
  localparam [15:0] S_RCRCL = 16'h4000;
  localparam [15:0] S_RCRCH = 16'h8000;

  reg [15:0] state_r;
  reg [7:0]  cnt_r;
  reg [7:0]  crc_lo_r;
  reg [7:0]  rlen_r;
  reg [7:0]  rres_r;
  reg        crc_init;
  reg        crc_en;
  reg [7:0]  crc_din;
  wire [15:0] crc_val;
  wire [15:0] crc_inv;

  function [3:0] decode_sel;
    input [7:0] code;
    begin
      decode_sel = 4'h0;
      case (code)
        `SCF_CMD_WRMEM:   decode_sel[`SCF_SEL_WR]    = 1'b1;
        `SCF_CMD_RDMEM:   decode_sel[`SCF_SEL_RD]    = 1'b1;
        `SCF_CMD_AUTH:    decode_sel[`SCF_SEL_AUTH]  = 1'b1;
        `SCF_CMD_STATUS,
        `SCF_CMD_PROT,
        `SCF_CMD_DECR,
        `SCF_CMD_DISABLE,
        `SCF_CMD_RNG,
        `SCF_CMD_KEYGEN:  decode_sel[`SCF_SEL_OTHER] = 1'b1;
        default:          decode_sel = 4'h0;
      endcase
    end
  endfunction

  // crc engine shared by command and response phases
  // crc polynomial
  scf_crc16 u_crc (
    .clk_sys (clk_sys),
    .rst     (rst),
    .init    (crc_init),
    .en      (crc_en),
    .din     (crc_din),
    .crc     (crc_val)
  );

  assign crc_inv = crc_val ^ `SCF_CRC_ONES;

  assign high_current_pull_phase = (state_r == S_EXEC);
  assign tx_valid = (state_r == S_RLEN) || (state_r == S_RRES) ||
                    ((state_r == S_RDATA) && res_data_valid) ||
                    (state_r == S_RCRCL) || (state_r == S_RCRCH);
  assign res_data_take = (state_r == S_RDATA) && tx_take && res_data_valid;

  // ------------------------------------------------------------
  // crc feed
  // ------------------------------------------------------------
  always @* begin
    crc_init = 1'b0;
    crc_en   = 1'b0;
    crc_din  = rx_data;
    case (state_r)
      S_START: crc_init = rx_valid;
      S_LEN, S_CODE, S_PARM: crc_en = rx_valid;
      S_DUMMY: crc_init = rx_valid;
      S_RLEN, S_RRES: begin
        crc_en  = tx_take;
        crc_din = tx_data;
      end
      S_RDATA: begin
        crc_en  = tx_take && res_data_valid;
        crc_din = res_data;
      end
      default: crc_en = 1'b0;
    endcase
  end

  // tx data is registered for all but pass-through result data
  always @* begin
    tx_data = 8'h00;
    case (state_r)
      S_RLEN:  tx_data = rlen_r;
      S_RRES:  tx_data = rres_r;
      S_RDATA: tx_data = res_data;
      // crc sent inverted, low byte first
      S_RCRCL: tx_data = crc_inv[7:0];
      S_RCRCH: tx_data = crc_inv[15:8];
      default: tx_data = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      state_r     <= S_WRST;
      cnt_r       <= 8'h00;
      crc_lo_r    <= 8'h00;
      rlen_r      <= 8'h00;
      rres_r      <= 8'h00;
      cmd_go      <= 1'b0;
      cmd_code    <= 8'h00;
      cmd_sel     <= 4'h0;
      param_valid <= 1'b0;
      param_data  <= 8'h00;
      param_idx   <= 8'h00;
      frame_err   <= 1'b0;
    end else begin
      cmd_go      <= 1'b0;
      param_valid <= 1'b0;
      frame_err   <= 1'b0;
      if (bus_reset) begin
        state_r <= S_WROM;
      end else begin
        case (state_r)
          S_WRST: state_r <= S_WRST;
          S_WROM: begin
            if (rom_sel_ok)
              state_r <= S_START;
          end
          S_START: begin
            // only start code opens a frame
            if (rx_valid) begin
              if (rx_data == `SCF_CMD_START) begin
                state_r <= S_LEN;
              end else begin
                state_r   <= S_WRST;
                frame_err <= 1'b1;
              end
            end
          end
          S_LEN: begin
            if (rx_valid) begin
              if (rx_data == 8'h00 || rx_data > MAX_LEN) begin
                state_r   <= S_WRST;
                frame_err <= 1'b1;
              end else begin
                cnt_r   <= rx_data - 8'h01;
                state_r <= S_CODE;
              end
            end
          end
          S_CODE: begin
            if (rx_valid) begin
              cmd_code  <= rx_data;
              cmd_sel   <= decode_sel(rx_data);
              param_idx <= 8'h00;
              if (decode_sel(rx_data) == 4'h0) begin
                state_r   <= S_WRST;
                frame_err <= 1'b1;
              end else if (cnt_r == 8'h00) begin
                state_r <= S_CRCL;
              end else begin
                state_r <= S_PARM;
              end
            end
          end
          S_PARM: begin
            if (rx_valid) begin
              param_valid <= 1'b1;
              param_data  <= rx_data;
              if (param_valid)
                param_idx <= param_idx + 8'h01;
              cnt_r <= cnt_r - 8'h01;
              if (cnt_r == 8'h01)
                state_r <= S_CRCL;
            end else if (param_valid) begin
              param_idx <= param_idx + 8'h01;
            end
          end
          S_CRCL: begin
            if (param_valid)
              param_idx <= param_idx + 8'h01;
            if (rx_valid) begin
              crc_lo_r <= rx_data;
              state_r  <= S_CRCH;
            end
          end
          S_CRCH: begin
            if (rx_valid) begin
              if ({rx_data, crc_lo_r} == crc_inv) begin
                state_r <= S_REL;
              end else begin
                state_r   <= S_WRST;
                frame_err <= 1'b1;
              end
            end
          end
          S_REL: begin
            if (rx_valid) begin
              if (rx_data == RELEASE_CODE) begin
                cmd_go  <= 1'b1;
                state_r <= S_EXEC;
              end else begin
                state_r   <= S_WRST;
                frame_err <= 1'b1;
              end
            end
          end
          S_EXEC: begin
            if (exec_done) begin
              rlen_r  <= res_len;
              rres_r  <= res_byte;
              state_r <= S_DUMMY;
            end
          end
          S_DUMMY: begin
            if (rx_valid)
              state_r <= S_RLEN;
          end
          S_RLEN: begin
            if (tx_take) begin
              cnt_r   <= (rlen_r == 8'h00) ? 8'h00 : rlen_r - 8'h01;
              state_r <= (rlen_r == 8'h00) ? S_RCRCL : S_RRES;
            end
          end
          S_RRES: begin
            // data only if length says so
            if (tx_take)
              state_r <= (cnt_r == 8'h00) ? S_RCRCL : S_RDATA;
          end
          S_RDATA: begin
            if (tx_take && res_data_valid) begin
              cnt_r <= cnt_r - 8'h01;
              if (cnt_r == 8'h01)
                state_r <= S_RCRCL;
            end
          end
          S_RCRCL: begin
            if (tx_take)
              state_r <= S_RCRCH;
          end
          S_RCRCH: begin
            if (tx_take)
              state_r <= S_WRST;
          end
          default: state_r <= S_WRST;
        endcase
      end
    end
  end

endmodule

//--- tb/scf_framer_properties.sv
// assertions on the ports of the command framing engine
`timescale 1ns/1ps

module scf_framer_properties #(
  parameter [7:0] RELEASE_CODE = 8'haa
) (
  input logic       clk_sys,
  input logic       rst,
  input logic       bus_reset,
  input logic       rom_sel_ok,
  input logic       rx_valid,
  input logic [7:0] rx_data,
  input logic       tx_valid,
  input logic [7:0] tx_data,
  input logic       tx_take,
  input logic       cmd_go,
  input logic [7:0] cmd_code,
  input logic [3:0] cmd_sel,
  input logic       param_valid,
  input logic [7:0] param_data,
  input logic [7:0] res_data,
  input logic       res_data_take,
  input logic       high_current_pull_phase,
  input logic       frame_err
);
  logic sel_seen_r;

  function automatic logic [3:0] sel_of(input logic [7:0] c);
    case (c)
      8'h96: sel_of = 4'h1;
      8'h44: sel_of = 4'h2;
      8'ha5: sel_of = 4'h4;
      default: sel_of = 4'h8;
    endcase
  endfunction

  // rom select seen since the last bus reset
  always @(posedge clk_sys) begin
    if (rst || bus_reset)
      sel_seen_r <= 1'b0;
    else if (rom_sel_ok)
      sel_seen_r <= 1'b1;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_go_after_select: assert property (cmd_go |-> sel_seen_r)
    else $error("command run without rom select");
  a_sel_decode: assert property (cmd_go |-> cmd_sel == sel_of(cmd_code))
    else $error("select does not match function code");
  a_go_release: assert property (cmd_go |-> $past(rx_valid) &&
    $past(rx_data) == RELEASE_CODE) else $error("go without release byte");
  a_pull_go: assert property ($rose(high_current_pull_phase) |-> cmd_go)
    else $error("pull phase without go");
  a_quiet_pull: assert property (high_current_pull_phase |-> !tx_valid)
    else $error("byte offered during pull phase");
  a_param_copy: assert property (param_valid |-> $past(rx_valid) &&
    param_data == $past(rx_data)) else $error("parameter not copied");
  a_data_pass: assert property (res_data_take |->
    tx_take && tx_data == res_data) else $error("result data not passed");
  a_tx_hold: assert property (tx_valid && !tx_take && !bus_reset |=>
    tx_valid && $stable(tx_data)) else $error("tx byte dropped early");

  cover property (cmd_go && cmd_sel == 4'h8);
  cover property (frame_err);
  cover property (res_data_take);
endmodule

bind scf_framer scf_framer_properties #(.RELEASE_CODE(RELEASE_CODE))
  u_props (.clk_sys, .rst, .bus_reset, .rom_sel_ok, .rx_valid, .rx_data,
    .tx_valid, .tx_data, .tx_take, .cmd_go, .cmd_code, .cmd_sel,
    .param_valid, .param_data, .res_data, .res_data_take,
    .high_current_pull_phase, .frame_err);

//--- tb/scf_host_model.sv
// bus master model: link setup, command frames, response reads
`timescale 1ns/1ps

module scf_host_model (
  input  logic       clk_sys,
  output logic       bus_reset,
  output logic       rom_sel_ok,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       tx_take,
  input  logic       tx_valid,
  input  logic [7:0] tx_data,
  output logic       hung
);
  initial begin
    {bus_reset, rom_sel_ok, rx_valid, tx_take, hung} = 5'h00;
    rx_data = 8'h00;
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    integer i;
    crc_step = c;
    for (i = 0; i < 8; i = i + 1) begin
      crc_step = (crc_step >> 1) ^ ((crc_step[0] ^ d[i]) ? 16'ha001 : 16'h0);
    end
  endfunction

  task automatic put(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge clk_sys);
  endtask

  // released line shows the inverse of the last byte
  task automatic idle();
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    @(negedge clk_sys);
  endtask

  task automatic link(input logic sel);
    bus_reset = 1'b1;
    @(negedge clk_sys);
    bus_reset = 1'b0;
    rom_sel_ok = sel;
    @(negedge clk_sys);
    rom_sel_ok = 1'b0;
  endtask

  task automatic command(input logic [7:0] code, input logic [7:0] np,
                         input logic [7:0] rel, input logic [15:0] flip);
    logic [15:0] c;
    integer i;
    put(8'h66);
    put(np + 8'h01);
    put(code);
    c = crc_step(crc_step(16'h0000, np + 8'h01), code);
    for (i = 0; i < np; i = i + 1) begin
      put(8'h10 + i[7:0]);
      c = crc_step(c, 8'h10 + i[7:0]);
    end
    c = ~c ^ flip;
    put(c[7:0]);
    put(c[15:8]);
    put(rel);
    idle();
  endtask

  // take one response byte, after dly extra cycles
  task automatic get(input integer dly, output logic [7:0] b);
    integer n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    hung = (n == 60);
    repeat (dly) @(negedge clk_sys);
    b = tx_data;
    tx_take = 1'b1;
    @(negedge clk_sys);
    tx_take = 1'b0;
    @(negedge clk_sys);
  endtask
endmodule

//--- tb/tb.sv
// self-checking bench for the command framing engine
`timescale 1ns/1ps
`include "scf_consts.vh"

module tb;
  logic        clk_sys = 1'b0, rst = 1'b1, exec_done = 1'b0;
  logic        res_data_valid = 1'b1, hung;
  logic        bus_reset, rom_sel_ok, rx_valid, tx_valid, tx_take, cmd_go;
  logic        param_valid, res_data_take, high_current_pull_phase, frame_err;
  logic [7:0]  rx_data, tx_data, cmd_code, param_data, param_idx, res_data;
  logic [7:0]  res_len = 8'h00, res_byte = 8'h00, dnum = 8'h00;
  logic [7:0]  go_cnt, err_cnt, par_cnt, code, np, rl, sel, b, exp_b;
  logic        cnt_clr = 1'b0, idx_bad;
  logic [3:0]  cmd_sel, sel_seen;
  logic [15:0] c;
  integer      failures = 0, total_checks = 0, i, k;
  // code, parameter count, result length, expected select
  logic [31:0] rows [0:8] = '{32'haa010408, 32'h96020101, 32'h44010502,
    32'ha5020304, 32'hc3020108, 32'hc9030008, 32'h333f0108,
    32'hd2010608, 32'hcb010208};

  scf_framer uut (.clk_sys, .rst, .bus_reset, .rom_sel_ok, .rx_valid,
    .rx_data, .tx_valid, .tx_data, .tx_take, .cmd_go, .cmd_code, .cmd_sel,
    .param_valid, .param_data, .param_idx, .exec_done, .res_len, .res_byte,
    .res_data_valid, .res_data, .res_data_take, .high_current_pull_phase,
    .frame_err);
  scf_host_model hm (.clk_sys, .bus_reset, .rom_sel_ok, .rx_valid,
    .rx_data, .tx_take, .tx_valid, .tx_data, .hung);

  always #5 clk_sys = ~clk_sys;
  assign res_data = 8'hc0 ^ dnum;

  always @(posedge clk_sys) begin
    if (cmd_go) sel_seen <= cmd_sel;
    if (cnt_clr) begin
      {go_cnt, err_cnt, par_cnt, dnum} <= 32'h0;
      idx_bad <= 1'b0;
    end else begin
      if (cmd_go) go_cnt <= go_cnt + 8'h01;
      if (frame_err) err_cnt <= err_cnt + 8'h01;
      if (param_valid) par_cnt <= par_cnt + 8'h01;
      if (res_data_take) dnum <= dnum + 8'h01;
      // parameters arrive in order, with their index beside them
      if (param_valid && (param_idx !== par_cnt ||
          param_data !== 8'h10 + par_cnt))
        idx_bad <= 1'b1;
    end
  end

  // counters are cleared by their own process only
  task automatic clear();
    cnt_clr = 1'b1;
    @(negedge clk_sys);
    cnt_clr = 1'b0;
  endtask

  always @(posedge hung) begin
    failures = failures + 1;
    wrap_up();
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks = total_checks + 1;
    if (seen !== want) begin
      failures = failures + 1;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check({tx_valid, high_current_pull_phase, frame_err}, 16'h0);
    $display("reset done");
    for (i = 0; i < 9; i = i + 1) begin
      {code, np, rl, sel} = rows[i];
      clear();
      hm.link(1'b1);
      hm.command(code, np, `SCF_RELEASE_DEF, 16'h0);
      // early dummy must be ignored while the command runs
      hm.put(8'h5a);
      hm.idle();
      check(tx_valid, 16'h0);
      check(go_cnt, 16'h1);
      check(sel_seen, sel[3:0]);
      check(par_cnt, np);
      check(idx_bad, 16'h0);
      check(cmd_code, code);
      check(high_current_pull_phase, 16'h1);
      res_len = rl;
      res_byte = 8'h30 + i[7:0];
      exec_done = 1'b1;
      @(negedge clk_sys);
      exec_done = 1'b0;
      @(negedge clk_sys);
      check(high_current_pull_phase, 16'h0);
      hm.put(8'h5a);
      hm.idle();
      c = 16'h0;
      for (k = 0; k < (rl == 0 ? 1 : rl + 1); k = k + 1) begin
        exp_b = k == 0 ? rl : k == 1 ? res_byte : 8'hc0 ^ (k[7:0] - 8'h02);
        // odd rows hold result data back until the bench looks
        if (k == 1) res_data_valid = (i % 2 == 0);
        if (k == 2 && !res_data_valid) begin
          check(tx_valid, 16'h0);
          res_data_valid = 1'b1;
        end
        hm.get(i % 2 * 3, b);
        check(b, exp_b);
        c = hm.crc_step(c, exp_b);
      end
      res_data_valid = 1'b1;
      c = ~c;
      hm.get(0, b);
      check(b, c[7:0]);
      hm.get(3, b);
      check(b, c[15:8]);
      check(tx_valid, 16'h0);
      $display("command %h done", code);
    end
    // bad crc, wrong release, unknown code, then no rom select
    for (i = 0; i < 4; i = i + 1) begin
      clear();
      hm.link(i != 3);
      hm.command(i == 2 ? 8'h01 : 8'h44, 8'h01,
        i == 1 ? 8'h55 : `SCF_RELEASE_DEF, i == 0 ? 16'h0100 : 16'h0);
      repeat (3) @(negedge clk_sys);
      check(err_cnt, i != 3);
      check(go_cnt, 16'h0);
      $display("refusal %0d done", i);
    end
    // reset in mid-frame, then a frame with no link setup
    clear();
    hm.link(1'b1);
    hm.put(`SCF_CMD_START);
    rst = 1'b1;
    hm.idle();
    hm.idle();
    rst = 1'b0;
    check({tx_valid, high_current_pull_phase, frame_err}, 16'h0);
    hm.command(8'h44, 8'h01, `SCF_RELEASE_DEF, 16'h0);
    repeat (3) @(negedge clk_sys);
    check(go_cnt, 16'h0);
    check(err_cnt, 16'h0);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
